// File: rtl/lmsd_top.sv
`timescale 1ns/10ps
`include "lmsd_params.svh"
// Functional notes
// - Six sink channels and three row switches address up to eighteen LEDs.
// - Every sink channel holds an 8-bit current level, 256 steps.
// - Every sink channel has its own 12-bit PWM duty generator.
// - Three row outputs drive external PMOS switches, time-multiplexed by the MCU.
// - MCU reloads levels and duties and steps rows one, two, three repeatedly.
// - Four-bit global ceiling selects one of sixteen currents for all sinks.
// - Global ceiling at 0x0b is written only by the I2C host.
// - Per-channel current levels are written only by the MCU.
// - Channel current equals ceiling times 256 times level divided by 255.
// - PWM period length is set only by the MCU.
// - An interrupt to the MCU is raised at every PWM period end.
module lmsd_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic mcu_wr,
  input wire logic [2:0] mcu_sel,
  input wire logic [7:0] mcu_level,
  input wire logic [11:0] mcu_duty,
  input wire logic mcu_row_wr,
  input wire logic [1:0] mcu_row,
  input wire logic mcu_presc_wr,
  input wire logic [7:0] mcu_presc,
  output logic period_irq,
  output logic [5:0] sink_on,
  output logic [71:0] channel_output_current,
  output logic [2:0] row_switches_n,
  output logic [11:0] pwm_count
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [11:0] lmsd_scale(input logic [3:0] c, input logic [7:0] l);
    logic [19:0] p;
    p = 20'({c, 8'h00}) * 20'(l);
    return 12'(p / `LMSD_LVL_FULL);
  endfunction : lmsd_scale

  function automatic logic [2:0] lmsd_row_n(input logic [1:0] sel);
    logic [2:0] r;
    r = `LMSD_ROW_OFF_N;
    case (sel)
      `LMSD_ROW_FIRST: r = `LMSD_ROW1_N;
      `LMSD_ROW_SECOND: r = `LMSD_ROW2_N;
      `LMSD_ROW_THIRD: r = `LMSD_ROW3_N;
      default: r = `LMSD_ROW_OFF_N;
    endcase
    return r;
  endfunction : lmsd_row_n

  function automatic logic lmsd_is_gmax(input logic [7:0] a);
    return a == `LMSD_GMAX_ADDR;
  endfunction : lmsd_is_gmax

  // ****************************************************************
  // Host side: global ceiling register
  // ****************************************************************
  logic [7:0] gmax;
  logic [7:0] next_gmax;
  logic [7:0] next_host_rdata;

  always_comb begin
    next_gmax = gmax;
    next_host_rdata = `LMSD_RDATA_ZERO;
    if (host_wr && lmsd_is_gmax(host_addr)) begin
      next_gmax = host_wdata;
    end
    if (host_rd && lmsd_is_gmax(host_addr)) begin
      next_host_rdata = gmax;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gmax <= `LMSD_GMAX_RST;
      host_rdata <= `LMSD_RDATA_ZERO;
    end else begin
      gmax <= next_gmax;
      host_rdata <= next_host_rdata;
    end
  end

  // ****************************************************************
  // MCU side: shadows, active copies, PWM and row scan
  // ****************************************************************
  lmsd_pkg::lmsd_level_t level_sh [`LMSD_NCH];
  lmsd_pkg::lmsd_level_t level_act [`LMSD_NCH];
  lmsd_pkg::lmsd_duty_t duty_sh [`LMSD_NCH];
  lmsd_pkg::lmsd_duty_t duty_act [`LMSD_NCH];
  lmsd_pkg::lmsd_level_t next_level_sh [`LMSD_NCH];
  lmsd_pkg::lmsd_level_t next_level_act [`LMSD_NCH];
  lmsd_pkg::lmsd_duty_t next_duty_sh [`LMSD_NCH];
  lmsd_pkg::lmsd_duty_t next_duty_act [`LMSD_NCH];
  lmsd_pkg::lmsd_state_t state;
  lmsd_pkg::lmsd_state_t next_state;
  logic [1:0] row_sh;
  logic [1:0] next_row_sh;
  logic [7:0] presc;
  logic [7:0] next_presc;
  logic [7:0] pre;
  logic [7:0] next_pre;
  logic [11:0] next_pwm_count;
  logic [2:0] next_row_switches_n;
  logic [5:0] next_sink_on;
  logic [5:0] duty_mask;
  logic [71:0] next_cur;
  logic next_period_irq;
  logic tick;
  logic boundary;

  always_comb begin
    next_level_sh = level_sh;
    next_duty_sh = duty_sh;
    next_level_act = level_act;
    next_duty_act = duty_act;
    next_row_sh = row_sh;
    next_presc = presc;
    next_state = state;
    next_row_switches_n = row_switches_n;
    next_period_irq = 1'b0;
    next_sink_on = `LMSD_SINK_OFF;
    if (mcu_wr && mcu_sel < `LMSD_NCH_IDX) begin
      next_level_sh[mcu_sel] = mcu_level;
      next_duty_sh[mcu_sel] = mcu_duty;
    end
    if (mcu_row_wr) begin
      next_row_sh = mcu_row;
    end
    if (mcu_presc_wr) begin
      next_presc = mcu_presc;
    end
    tick = (pre == presc);
    next_pre = tick ? `LMSD_PRE_RST : 8'(pre + 8'h01);
    next_pwm_count = tick ? 12'(pwm_count + 12'h001) : pwm_count;
    boundary = tick && pwm_count == `LMSD_PWM_LAST;
    for (int i = 0; i < `LMSD_NCH; i++) begin
      duty_mask[i] = pwm_count < duty_act[i];
      next_cur[i*`LMSD_CUR_W +: `LMSD_CUR_W] = lmsd_scale(gmax[3:0], level_act[i]);
    end
    case (state)
      lmsd_pkg::LMSD_RUN: begin
        if (boundary) begin
          // Sinks drop one cycle before the rows move
          next_state = lmsd_pkg::LMSD_BLANK;
          next_period_irq = 1'b1;
        end else begin
          next_sink_on = duty_mask;
        end
      end
      lmsd_pkg::LMSD_BLANK: begin
        next_level_act = level_sh;
        next_duty_act = duty_sh;
        next_row_switches_n = lmsd_row_n(row_sh);
        next_state = lmsd_pkg::LMSD_RUN;
      end
      default: begin
        next_state = lmsd_pkg::LMSD_RUN;
        next_row_switches_n = `LMSD_ROW_OFF_N;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < `LMSD_NCH; i++) begin
        level_sh[i] <= `LMSD_LVL_RST;
        level_act[i] <= `LMSD_LVL_RST;
        duty_sh[i] <= `LMSD_DUTY_RST;
        duty_act[i] <= `LMSD_DUTY_RST;
      end
      state <= lmsd_pkg::LMSD_RUN;
      row_sh <= `LMSD_ROW_NONE;
      presc <= `LMSD_PRE_RST;
      pre <= `LMSD_PRE_RST;
      pwm_count <= `LMSD_CNT_RST;
      row_switches_n <= `LMSD_ROW_OFF_N;
      sink_on <= `LMSD_SINK_OFF;
      period_irq <= 1'b0;
      channel_output_current <= `LMSD_CUR_RST;
    end else begin
      level_sh <= next_level_sh;
      level_act <= next_level_act;
      duty_sh <= next_duty_sh;
      duty_act <= next_duty_act;
      state <= next_state;
      row_sh <= next_row_sh;
      presc <= next_presc;
      pre <= next_pre;
      pwm_count <= next_pwm_count;
      row_switches_n <= next_row_switches_n;
      sink_on <= next_sink_on;
      period_irq <= next_period_irq;
      channel_output_current <= next_cur;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_one_row: assert property ($onehot0(~row_switches_n))
    else $error("more than one row switch on");

  chk_row_dark: assert property (
    $changed(row_switches_n) |-> (sink_on == 6'h00 && $past(sink_on) == 6'h00))
    else $error("sinks on while row changed");

  chk_irq_pulse: assert property (
    period_irq |-> (pwm_count == 12'h000 && state == lmsd_pkg::LMSD_BLANK) ##1 !period_irq)
    else $error("period interrupt misplaced");

  chk_irq_cause: assert property (
    $rose(period_irq) |-> $past(pwm_count) == `LMSD_PWM_LAST && $past(pre) == $past(presc))
    else $error("interrupt without period end");

  chk_shadow_apply: assert property (
    ($changed(duty_act[0]) || $changed(level_act[0])) |-> $past(state) == lmsd_pkg::LMSD_BLANK)
    else $error("active values changed mid period");

  chk_gmax_host: assert property (
    $changed(gmax) |-> $past(host_wr) && $past(host_addr) == `LMSD_GMAX_ADDR)
    else $error("ceiling changed without host write");

  chk_level_scale: assert property (
    channel_output_current[11:0] == lmsd_scale($past(gmax[3:0]), $past(level_act[0])))
    else $error("channel current scaling wrong");

  chk_duty_gate: assert property (
    ($past(state) == lmsd_pkg::LMSD_RUN && !$past(boundary)) |->
      sink_on[0] == ($past(pwm_count) < $past(duty_act[0])))
    else $error("sink gate disagrees with duty");

  chk_host_read: assert property (
    (host_rd && host_addr == `LMSD_GMAX_ADDR) |=> host_rdata == $past(gmax))
    else $error("ceiling readback wrong");

  chk_row_apply: assert property (
    $changed(row_switches_n) |-> $past(state) == lmsd_pkg::LMSD_BLANK)
    else $error("row moved outside the blank cycle");

  chk_row_follow: assert property (
    $past(state) == lmsd_pkg::LMSD_BLANK |-> row_switches_n == lmsd_row_n($past(row_sh)))
    else $error("row drive differs from selection");

  chk_presc_step: assert property (
    $changed(pwm_count) |-> $past(pre) == $past(presc))
    else $error("counter moved off prescaler tick");

  chk_count_step: assert property (
    $changed(pwm_count) |-> pwm_count == 12'($past(pwm_count) + 12'h001))
    else $error("counter skipped a step");

  chk_blank_dark: assert property (
    state == lmsd_pkg::LMSD_BLANK |-> sink_on == `LMSD_SINK_OFF)
    else $error("sinks on in blank cycle");

  chk_irq_dark: assert property (
    period_irq |-> sink_on == `LMSD_SINK_OFF)
    else $error("sinks on at period end");

  chk_level_write: assert property (
    $changed(level_sh[0]) |-> $past(mcu_wr) && $past(mcu_sel) == 3'h0)
    else $error("level shadow changed without firmware write");

  chk_presc_write: assert property (
    $changed(presc) |-> $past(mcu_presc_wr))
    else $error("prescaler changed without firmware write");

  chk_ceiling_write: assert property (
    ($past(host_wr) && lmsd_is_gmax($past(host_addr))) |-> gmax == $past(host_wdata))
    else $error("ceiling write lost");

  chk_last_apply: assert property (
    ($changed(duty_act[`LMSD_CH_LAST]) || $changed(level_act[`LMSD_CH_LAST])) |->
      $past(state) == lmsd_pkg::LMSD_BLANK)
    else $error("last channel changed mid period");

  chk_last_scale: assert property (
    channel_output_current[`LMSD_CH_LAST * `LMSD_CUR_W +: `LMSD_CUR_W] ==
      lmsd_scale($past(gmax[3:0]), $past(level_act[`LMSD_CH_LAST])))
    else $error("last channel current scaling wrong");

  chk_last_gate: assert property (
    ($past(state) == lmsd_pkg::LMSD_RUN && !$past(boundary)) |->
      sink_on[`LMSD_CH_LAST] == ($past(pwm_count) < $past(duty_act[`LMSD_CH_LAST])))
    else $error("last sink gate disagrees with duty");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  cov_period_end: cover property (period_irq);
  cov_row_change: cover property ($changed(row_switches_n) && row_switches_n != `LMSD_ROW_OFF_N);
  cov_sink_on: cover property (sink_on[0] && !row_switches_n[0]);
  cov_row_third: cover property (row_switches_n == `LMSD_ROW3_N);
  cov_presc_slow: cover property (period_irq && presc != `LMSD_PRE_RST);

endmodule : lmsd_top

// File: rtl/lmsd_params.svh
`ifndef LMSD_PARAMS_SVH
`define LMSD_PARAMS_SVH
// Channel and row counts
`define LMSD_NCH 6
`define LMSD_NCH_IDX 3'h6
`define LMSD_NROW 3
// Field widths
`define LMSD_LVL_W 8
`define LMSD_PWM_W 12
`define LMSD_CUR_W 12
`define LMSD_PRE_W 8
`define LMSD_GMAX_W 4
// Host register map
`define LMSD_GMAX_ADDR 8'h0b
`define LMSD_GMAX_RST 8'h00
`define LMSD_RDATA_ZERO 8'h00
// Full-scale channel level, divisor of the current scaling
`define LMSD_LVL_FULL 20'h0_00ff
// Last count of a PWM period
`define LMSD_PWM_LAST 12'hfff
// Row selection codes and active-low row drive
`define LMSD_ROW_NONE 2'h0
`define LMSD_ROW_FIRST 2'h1
`define LMSD_ROW_SECOND 2'h2
`define LMSD_ROW_THIRD 2'h3
`define LMSD_ROW_OFF_N 3'h7
`define LMSD_PRE_RST 8'h00
// Row drive codes, one low bit per active row
`define LMSD_ROW1_N 3'h6
`define LMSD_ROW2_N 3'h5
`define LMSD_ROW3_N 3'h3
// Reset values of the channel state
`define LMSD_LVL_RST 8'h00
`define LMSD_DUTY_RST 12'h000
`define LMSD_CNT_RST 12'h000
`define LMSD_SINK_OFF 6'h00
`define LMSD_CUR_RST 72'h00_0000_0000_0000_0000
// Channel watched by the last-channel checks
`define LMSD_CH_LAST 5
`endif

// File: rtl/lmsd_pkg.sv
package lmsd_pkg;
  typedef enum logic {
    LMSD_RUN,
    LMSD_BLANK
  } lmsd_state_t;
  typedef logic [7:0] lmsd_level_t;
  typedef logic [11:0] lmsd_duty_t;
endpackage : lmsd_pkg

// File: tb/lmsd_mcu_model.sv
`timescale 1ns/10ps
module lmsd_mcu_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic period_irq,
  output logic mcu_row_wr,
  output logic [1:0] mcu_row
);
  // Firmware side: picks the next row on every period interrupt
  always_ff @(posedge clock) begin
    if (rst) begin
      mcu_row_wr <= 1'b1;
      mcu_row <= 2'h1;
    end else begin
      mcu_row_wr <= period_irq;
      if (period_irq) begin
        mcu_row <= (mcu_row == 2'h3) ? 2'h1 : mcu_row + 2'h1;
      end
    end
  end
endmodule : lmsd_mcu_model

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [7:0] lvl; logic [11:0] duty; logic [11:0] prb; logic on;} lmsd_case_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic host_wr = 1'b0, host_rd = 1'b0, mcu_wr = 1'b0, mcu_presc_wr = 1'b0;
  logic period_irq, mcu_row_wr;
  logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, rd;
  logic [7:0] mcu_level = 8'h00, mcu_presc = 8'h00;
  logic [2:0] mcu_sel = 3'h0, row_switches_n, r_a, r_b, r_c;
  logic [11:0] mcu_duty = 12'h000, pwm_count;
  logic [1:0] mcu_row;
  logic [5:0] sink_on;
  logic [71:0] channel_output_current;
  int miscompares = 0;
  int n_checks = 0;
  int cyc;
  // Probe counts ascend so one period serves every channel
  lmsd_case_t cases [6] = '{'{8'hff, 12'hfff, 12'h003, 1'b1}, '{8'h80, 12'h000, 12'h004, 1'b0},
    '{8'h00, 12'h800, 12'h7ff, 1'b1}, '{8'h01, 12'h801, 12'h800, 1'b1},
    '{8'h7f, 12'h001, 12'h801, 1'b0}, '{8'hfe, 12'hfff, 12'hffe, 1'b1}};
  lmsd_top u_lmsd_top (.clock(clock), .rst(rst), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .mcu_wr(mcu_wr),
    .mcu_sel(mcu_sel), .mcu_level(mcu_level), .mcu_duty(mcu_duty), .mcu_row_wr(mcu_row_wr),
    .mcu_row(mcu_row), .mcu_presc_wr(mcu_presc_wr), .mcu_presc(mcu_presc),
    .period_irq(period_irq), .sink_on(sink_on), .channel_output_current(channel_output_current),
    .row_switches_n(row_switches_n), .pwm_count(pwm_count));
  lmsd_mcu_model u_lmsd_mcu_model (.clock(clock), .rst(rst), .period_irq(period_irq),
    .mcu_row_wr(mcu_row_wr), .mcu_row(mcu_row));
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  task automatic host(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    host_wr <= !r;
    host_rd <= r;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clock);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    #1;
    rd = host_rdata;
  endtask : host
  task automatic wait_irq;
    cyc = 0;
    do begin
      @(posedge clock);
      #1;
      cyc++;
    end while (period_irq !== 1'b1 && cyc < 9000);
    chk("irq", 12'(period_irq), 12'h001);
    chk("blank", 12'(sink_on), 12'h000);
    @(posedge clock);
    #1;
    chk("pulse", 12'(period_irq), 12'h000);
    chk("blank2", 12'(sink_on), 12'h000);
    chk("one row", 12'($countones(~row_switches_n)), 12'h001);
  endtask : wait_irq
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("rows idle", 12'(row_switches_n), 12'h007);
    host(1'b0, 8'h0b, 8'h3c);
    host(1'b0, 8'h0a, 8'hff);
    host(1'b1, 8'h0a, 8'h00);
    chk("unmapped", 12'(rd), 12'h000);
    host(1'b1, 8'h0b, 8'h00);
    chk("ceiling", 12'(rd), 12'h03c);
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      mcu_wr <= 1'b1;
      mcu_sel <= 3'(i);
      mcu_level <= (i < 6) ? cases[i].lvl : 8'hff;
      mcu_duty <= (i < 6) ? cases[i].duty : 12'hfff;
    end
    @(posedge clock);
    mcu_wr <= 1'b0;
    #1;
    chk("shadowed", 12'(channel_output_current != 72'h0), 12'h000);
    wait_irq();
    r_a = row_switches_n;
    @(posedge clock);
    #1;
    for (int i = 0; i < 6; i++) begin
      chk("current", channel_output_current[12*i +: 12],
        12'((12 * 256 * int'(cases[i].lvl)) / 255));
      for (int k = 0; k < 5000 && pwm_count !== cases[i].prb; k++) begin
        @(posedge clock);
        #1;
      end
      chk("probe", pwm_count, cases[i].prb);
      chk("gate", 12'(sink_on[i]), 12'(cases[i].on));
    end
    wait_irq();
    r_b = row_switches_n;
    wait_irq();
    r_c = row_switches_n;
    chk("row turns", 12'(r_a & r_b & r_c), 12'h000);
    @(posedge clock);
    mcu_presc_wr <= 1'b1;
    mcu_presc <= 8'h01;
    @(posedge clock);
    mcu_presc_wr <= 1'b0;
    wait_irq();
    wait_irq();
    chk("period", 12'(cyc), 12'(8192 - 1));
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk("reset rows", 12'(row_switches_n), 12'h007);
    chk("reset sinks", 12'(sink_on), 12'h000);
    chk("reset irq", 12'(period_irq), 12'h000);
    chk("reset current", 12'(channel_output_current != 72'h0), 12'h000);
    host(1'b1, 8'h0b, 8'h00);
    chk("reset ceiling", 12'(rd), 12'h000);
    wait_irq();
    chk("restart row", 12'(row_switches_n), 12'h006);
    tally_and_finish();
  end
endmodule : tb_top
